/* File: rtl/adc_spi_master_reader.sv */
// Serial port that reads a 10-bit multi-channel converter as master,
// with a plain one-byte slave mode. Assumes all pins are asynchronous.
//
// Contract
// (RQ1) Master shifts each byte out most significant bit first.
// (RQ2) Clock pin drives out as master, is an input as slave.
// (RQ3) Data-in pin reads as master, drives out as slave.
// (RQ4) Slave select low enables slave transfers; held high in master mode.
// (RQ5) Data is shifted on one clock edge and sampled on the other.
// (RQ6) Master drives data on rising edge, captures on falling edge.
// (RQ7) Chip select goes low before any serial clock edge.
// (RQ8) Two back-to-back bytes form one 16-bit exchange under one select.
// (RQ9) First byte sends channel, returns upper 8 result bits as high byte.
// (RQ10) Second byte returns the 2 low bits on top, stored as low byte.
// (RQ11) Channel address sits in the upper nibble of the sent byte.
// (RQ12) Each exchange returns the previous result; first one is discarded.
// (RQ13) End-of-conversion low means busy; wait for high before starting.
// (RQ14) Converter takes a 4-bit address MSB first on rising edges.
// (RQ15) Converter drives zero after its 10 result bits.
// (RQ16) Converter pulls end-of-conversion low on tenth falling edge.
// (RQ17) Converter output floats and input ignored while select is high; the model drives the inverse of its last bit instead.
// (RQ18) Select returns high after the second byte, before a new exchange.
`default_nettype none

module adc_spi_master_reader
  import adc_spi_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_CYC,
  parameter int CS_IDLE  = CS_IDLE_CYC
)(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Control
  input  wire logic              slave_mode,
  input  wire logic              start,
  input  wire logic [CHAN_W-1:0] channel,
  output logic                   busy,
  // Results
  output logic [BYTE_W-1:0]      result_hi_ff,
  output logic [BYTE_W-1:0]      result_lo_ff,
  output logic [RES_W-1:0]       result_ff,
  output logic                   result_valid_ff,
  output logic                   tail_err_ff,
  output logic                   eoc_missed_ff,
  output logic                   conv_done,
  // Slave user side
  input  wire logic [BYTE_W-1:0] slave_tx_byte,
  output logic [BYTE_W-1:0]      slave_rx_byte_ff,
  output logic                   slave_rx_valid_ff,
  // Pins
  output logic                   cs_n_ff,
  input  wire logic              sck_i,
  output logic                   sck_ff,
  output logic                   sck_oe,
  input  wire logic              mosi_i,
  output logic                   mosi_o,
  output logic                   mosi_oe,
  input  wire logic              miso_i,
  output logic                   miso_o,
  output logic                   miso_oe,
  input  wire logic              ss_n_i,
  input  wire logic              eoc_i
);

  localparam int DIV_W = $clog2(SCK_HALF + CS_IDLE + 1);
  localparam logic [4:0] PIN_IDLE = 5'h18;

  generate
    if (SCK_HALF < 3 || CS_IDLE < 8) begin : g_bad_timing
      $error("adc_spi_master_reader: timing counts too small");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] meta_ff;
  logic [4:0] sync_ff;
  logic       sck_prev_ff;
  logic       ss_prev_ff;
  logic       sck_s, mosi_s, miso_s, ss_n_s, eoc_s;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_ff <= PIN_IDLE;
      sync_ff <= PIN_IDLE;
    end else begin
      meta_ff <= {eoc_i, ss_n_i, miso_i, mosi_i, sck_i};
      sync_ff <= meta_ff;
    end
  end

  assign {eoc_s, ss_n_s, miso_s, mosi_s, sck_s} = sync_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sck_prev_ff <= 1'b0;
      ss_prev_ff  <= 1'b1;
    end else begin
      sck_prev_ff <= sck_s;
      ss_prev_ff  <= ss_n_s;
    end
  end

  // ----------------------------------------------------------------
  // Master sequencer and clock divider
  // ----------------------------------------------------------------
  mst_state_t              state_ff;
  logic [DIV_W-1:0]        div_ff;
  logic                    byte_idx_ff;
  logic [CNT_W-1:0]        fall_cnt_ff;
  logic [CHAN_W-1:0]       chan_ff;
  logic [1:0]              seen_ff;
  logic                    tick;
  logic                    hold_tick;
  logic                    m_drive, m_sample, m_start;
  logic                    s_drive, s_sample, s_load;
  logic                    sh_load, sh_done, sh_sdo;
  logic [BYTE_W-1:0]       sh_data, sh_reg;

  assign tick      = (div_ff == DIV_W'(SCK_HALF - 1));
  assign hold_tick = (div_ff == DIV_W'(CS_IDLE - 1));
  assign m_start   = (state_ff == ST_IDLE) && !slave_mode && start && eoc_s; // RQ13
  assign m_drive   = (state_ff == ST_SHIFT) && tick && !sck_ff;             // RQ6
  assign m_sample  = (state_ff == ST_SHIFT) && tick && sck_ff;              // RQ6
  assign busy      = (state_ff != ST_IDLE);
  assign conv_done = eoc_s;

  always_ff @(posedge ref_clk) begin
    if (!rst_n || state_ff == ST_IDLE || (state_ff == ST_SETUP && tick) ||
        (state_ff == ST_SHIFT && tick) || (state_ff == ST_HOLD && hold_tick)) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + DIV_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff    <= ST_IDLE;
      cs_n_ff     <= 1'b1;
      byte_idx_ff <= 1'b0;
      chan_ff     <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (m_start) begin
            cs_n_ff     <= 1'b0; // RQ7
            chan_ff     <= channel;
            byte_idx_ff <= 1'b0;
            state_ff    <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (tick) begin
            state_ff <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (sh_done && byte_idx_ff) begin
            cs_n_ff  <= 1'b1; // RQ18
            state_ff <= ST_HOLD;
          end else if (sh_done) begin
            byte_idx_ff <= 1'b1; // RQ8
          end
        end
        ST_HOLD: begin
          if (hold_tick) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          cs_n_ff  <= 1'b1;
        end
      endcase
    end
  end

  // Serial clock idles low and only toggles while select is low.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || state_ff != ST_SHIFT) begin
      sck_ff <= 1'b0;
    end else if (tick) begin
      sck_ff <= !sck_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || m_start) begin
      fall_cnt_ff <= '0;
    end else if (m_sample) begin
      fall_cnt_ff <= fall_cnt_ff + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Slave side edge detection
  // ----------------------------------------------------------------
  // Slave clocking is limited to a few MHz by the two-stage pin sync.
  assign s_drive  = slave_mode && !ss_n_s && sck_s && !sck_prev_ff;  // RQ4 RQ5
  assign s_sample = slave_mode && !ss_n_s && !sck_s && sck_prev_ff;  // RQ4 RQ5
  assign s_load   = slave_mode && ((!ss_n_s && ss_prev_ff) || sh_done);

  // ----------------------------------------------------------------
  // Shared shifter
  // ----------------------------------------------------------------
  assign sh_load = m_start || (state_ff == ST_SHIFT && sh_done && !byte_idx_ff) || s_load;
  assign sh_data = slave_mode ? slave_tx_byte : {(m_start ? channel : chan_ff), CHAN_PAD}; // RQ11 RQ14

  spi_byte_shifter u_shifter (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .load      (sh_load),
    .load_data (sh_data),
    .drive_en  (m_drive || s_drive),
    .sample_en (m_sample || s_sample),
    .sdi       (slave_mode ? mosi_s : miso_s),
    .sdo_ff    (sh_sdo),
    .shreg_ff  (sh_reg),
    .done_ff   (sh_done)
  );

  // ----------------------------------------------------------------
  // Pin directions
  // ----------------------------------------------------------------
  assign sck_oe  = !slave_mode;               // RQ2
  assign mosi_oe = !slave_mode;               // RQ3
  assign miso_oe = slave_mode && !ss_n_s;     // RQ3 RQ4
  assign mosi_o  = sh_sdo && !slave_mode && !cs_n_ff;
  assign miso_o  = sh_sdo && slave_mode;

  // ----------------------------------------------------------------
  // Result capture
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      result_hi_ff <= '0;
      result_lo_ff <= '0;
    end else if (!slave_mode && state_ff == ST_SHIFT && sh_done) begin
      if (byte_idx_ff) begin
        result_lo_ff <= sh_reg; // RQ10
      end else begin
        result_hi_ff <= sh_reg; // RQ9
      end
    end
  end

  // The first exchange after reset carries no real conversion, so it
  // completes on the link but never raises the valid strobe.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      seen_ff         <= '0;
      result_valid_ff <= 1'b0;
      result_ff       <= '0;
    end else begin
      result_valid_ff <= 1'b0;
      if (state_ff == ST_HOLD && hold_tick) begin
        if (seen_ff != SEEN_TWO) begin
          seen_ff <= seen_ff + 2'h1;
        end
        result_ff       <= {result_hi_ff, result_lo_ff[BYTE_W-1 -: LOW_BITS]}; // RQ9 RQ10
        result_valid_ff <= (seen_ff != 2'h0); // RQ12
      end
    end
  end

  // Link sanity flags, sticky until reset.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tail_err_ff   <= 1'b0;
      eoc_missed_ff <= 1'b0;
    end else begin
      if (state_ff == ST_HOLD && hold_tick && result_lo_ff[BYTE_W-LOW_BITS-1:0] != '0) begin
        tail_err_ff <= 1'b1; // RQ15
      end
      if (m_drive && fall_cnt_ff == EOC_FALL && eoc_s) begin
        eoc_missed_ff <= 1'b1; // RQ16
      end
    end
  end

  // Slave side byte hand-off. The select gate keeps idle bus traffic out.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      slave_rx_byte_ff  <= '0;
      slave_rx_valid_ff <= 1'b0;
    end else begin
      slave_rx_valid_ff <= slave_mode && sh_done; // RQ17
      if (slave_mode && sh_done) begin
        slave_rx_byte_ff <= sh_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence sck_rise_s;
    !sck_ff ##1 sck_ff;
  endsequence

  sequence sck_fall_s;
    sck_ff ##1 !sck_ff;
  endsequence

  chk_select_before_clock: assert property (sck_ff |-> !cs_n_ff && $past(!cs_n_ff)) // RQ7
    else $error("serial clock high without chip select");
  chk_mosi_on_rise: assert property (sck_rise_s |-> mosi_o == $past(sh_reg[BYTE_W-1])) // RQ1
    else $error("mosi not updated with msb on rising edge");
  chk_sample_on_fall: assert property (m_sample |=> !sck_ff) // RQ5
    else $error("master sampled outside a falling edge");
  chk_mosi_stable_fall: assert property (sck_fall_s |-> $stable(mosi_o)) // RQ6
    else $error("mosi changed on falling edge");
  chk_two_bytes: assert property ($rose(cs_n_ff) |-> fall_cnt_ff == XCHG_FALLS) // RQ8
    else $error("exchange did not carry sixteen clocks");
  chk_channel_nibble: assert property (m_start |=> sh_reg == {chan_ff, CHAN_PAD}) // RQ11
    else $error("channel not in upper nibble");
  chk_result_pack: assert property (result_valid_ff |-> result_ff[LOW_BITS-1:0] == result_lo_ff[BYTE_W-1 -: LOW_BITS]
                                    && result_ff[RES_W-1:LOW_BITS] == result_hi_ff) // RQ9
    else $error("result not packed from both bytes");
  chk_first_discard: assert property (result_valid_ff |-> seen_ff != 2'h0 && $past(seen_ff) != 2'h0) // RQ12
    else $error("first exchange result reported");
  chk_start_on_eoc: assert property ($fell(cs_n_ff) |-> $past(eoc_s)) // RQ13
    else $error("exchange started while converter busy");
  chk_select_idle: assert property ($rose(cs_n_ff) |-> cs_n_ff [*8]) // RQ18
    else $error("chip select idle time too short");
  chk_pin_dirs: assert property (slave_mode |-> !sck_oe && !mosi_oe && (miso_oe == !ss_n_s)) // RQ2
    else $error("pin directions wrong in slave mode");
  chk_master_miso_in: assert property (!slave_mode |-> !miso_oe && sck_oe) // RQ3
    else $error("miso driven in master mode");

endmodule : adc_spi_master_reader

`default_nettype wire

/* File: rtl/adc_spi_pkg.sv */
// Constants, widths, timing and state encoding for the converter reader.
// Assumes a single 100 MHz clock; all link timing is derived from it.
`default_nettype none

package adc_spi_pkg;

  // ----------------------------------------------------------------
  // Clock and link timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_HALF_NS   = 500;
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_IDLE_NS    = 500;
  localparam int CS_IDLE_CYC   = (CS_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int BYTE_W   = 8;
  localparam int CHAN_W   = 4;
  localparam int RES_W    = 10;
  localparam int LOW_BITS = 2;
  localparam int CNT_W    = 5;
  localparam logic [CNT_W-1:0] XCHG_FALLS = 5'h10;
  localparam logic [CNT_W-1:0] EOC_FALL   = 5'h0A;
  localparam logic [CHAN_W-1:0] CHAN_PAD  = 4'h0;
  localparam logic [1:0]        SEEN_TWO  = 2'h2;

  // ----------------------------------------------------------------
  // Master sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_SHIFT,
    ST_HOLD
  } mst_state_t;

endpackage : adc_spi_pkg

`default_nettype wire

/* File: rtl/spi_byte_shifter.sv */
// Shared 8-bit shift register, transmit and receive in one word.
// Assumes drive and sample strobes are one-cycle pulses from the caller.
`default_nettype none

module spi_byte_shifter
  import adc_spi_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Control
  input  wire logic              load,
  input  wire logic [BYTE_W-1:0] load_data,
  input  wire logic              drive_en,
  input  wire logic              sample_en,
  // Serial
  input  wire logic              sdi,
  output logic                   sdo_ff,
  // Parallel
  output logic [BYTE_W-1:0]      shreg_ff,
  output logic                   done_ff
);

  logic [2:0] bit_cnt_ff;

  // ----------------------------------------------------------------
  // Shift register, most significant bit leaves first
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shreg_ff   <= '0;
      bit_cnt_ff <= '0;
    end else if (load) begin
      shreg_ff   <= load_data;
      bit_cnt_ff <= '0;
    end else if (sample_en) begin
      shreg_ff   <= {shreg_ff[BYTE_W-2:0], sdi}; // RQ1
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || load) begin
      sdo_ff <= 1'b0;
    end else if (drive_en) begin
      sdo_ff <= shreg_ff[BYTE_W-1]; // RQ1
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= sample_en && !load && (bit_cnt_ff == 3'h7);
    end
  end

endmodule : spi_byte_shifter

`default_nettype wire

/* File: verif/adc_conv_model.sv */
// Behavioural model of the ten-bit serial converter at the reader's far side.
// Assumes the reader drives select, clock and data in; times are in ns.
`default_nettype none

module adc_conv_model #(
  parameter int CONV_NS = 2000
)(
  // Link
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       din,
  output logic            dout,
  output logic            eoc,
  // Test control
  input  wire logic [9:0] sample_in,
  input  wire logic       bad_tail,
  input  wire logic       bad_eoc,
  output logic [3:0]      addr_ff
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [9:0] prev_res = 10'h155;  // Power-up garbage, arbitrary.
  logic [9:0] conv_res = 10'h000;
  logic [4:0] falls    = 5'h00;
  logic [2:0] rises    = 3'h0;
  logic       drv      = 1'b0;

  initial eoc = 1'b1;
  initial addr_ff = 4'h0;

  // A released line shows the inverse of its last level, so stale data never passes as valid.
  assign dout = cs_n ? ~drv : drv;

  always @(negedge cs_n) begin
    falls = 5'h00;
    rises = 3'h0;
    drv   = prev_res[9];
  end

  // The reader moves its data on the rising edge, so the bit is read a little later.
  always @(posedge sclk) begin
    if (!cs_n && rises < 3'h4) begin
      #5;
      addr_ff = {addr_ff[2:0], din};
      rises   = rises + 3'h1;
    end
  end

  always @(negedge sclk) begin
    if (!cs_n) begin
      falls = falls + 5'h01;
      drv   = (falls < 5'h0A) ? prev_res[9 - falls] : bad_tail;
      if (falls == 5'h0A && !bad_eoc) begin
        eoc      = 1'b0;
        conv_res = sample_in;
        fork
          begin
            #(CONV_NS);
            prev_res = conv_res;
            eoc      = 1'b1;
          end
        join_none
      end
    end
  end
endmodule : adc_conv_model

`default_nettype wire

/* File: verif/adc_spi_master_reader_tb.sv */
// Self-checking bench for the converter reader in master and slave modes.
// Assumes the design package, the design and the converter model are compiled first.
`default_nettype none

module adc_spi_master_reader_tb import adc_spi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // Short link timing keeps the run brief.
  localparam int H = 4;
  localparam int C = 8;

  logic        ref_clk = 1'b0, rst_n = 1'b0, slave_mode = 1'b0, start = 1'b0, ss_n_i = 1'b1;
  logic        tb_sck = 1'b0, tb_mosi = 1'b0, bad_tail = 1'b0, bad_eoc = 1'b0;
  logic [3:0]  channel = 4'h0, addr;
  logic [7:0]  slave_tx_byte = 8'h00, result_hi_ff, result_lo_ff, slave_rx_byte_ff;
  logic [9:0]  result_ff, sample_in = 10'h000;
  logic        busy, result_valid_ff, tail_err_ff, eoc_missed_ff, conv_done, slave_rx_valid_ff;
  logic        cs_n_ff, sck_ff, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, eoc, conv_dout;
  logic [15:0] mosi_cap = 16'h0000;
  wire         sck_pin, mosi_pin, miso_pin;
  int          failures = 0, check_count = 0, rise_cnt = 0, valid_cnt = 0, bad_starts = 0;

  assign sck_pin  = sck_oe ? sck_ff : tb_sck;
  assign mosi_pin = mosi_oe ? mosi_o : tb_mosi;
  assign miso_pin = miso_oe ? miso_o : conv_dout;

  adc_spi_master_reader #(.SCK_HALF(H), .CS_IDLE(C)) DUT (
    .ref_clk, .rst_n, .slave_mode, .start, .channel, .busy,
    .result_hi_ff, .result_lo_ff, .result_ff, .result_valid_ff, .tail_err_ff, .eoc_missed_ff, .conv_done,
    .slave_tx_byte, .slave_rx_byte_ff, .slave_rx_valid_ff,
    .cs_n_ff, .sck_i(sck_pin), .sck_ff, .sck_oe, .mosi_i(mosi_pin), .mosi_o, .mosi_oe,
    .miso_i(miso_pin), .miso_o, .miso_oe, .ss_n_i, .eoc_i(eoc)
  );

  adc_conv_model #(.CONV_NS(2000)) conv (
    .cs_n(cs_n_ff), .sclk(sck_pin), .din(mosi_pin), .dout(conv_dout), .eoc,
    .sample_in, .bad_tail, .bad_eoc, .addr_ff(addr)
  );

  always #5 ref_clk = ~ref_clk;

  // --------------------------------------------------------------
  // Link monitors
  // --------------------------------------------------------------
  always @(negedge cs_n_ff) begin
    rise_cnt = 0;
    if (eoc !== 1'b1) bad_starts++;
  end
  always @(posedge sck_pin) begin
    rise_cnt++;
    if (cs_n_ff !== 1'b0 && !slave_mode) bad_starts++;
  end
  always @(negedge sck_pin) mosi_cap = {mosi_cap[14:0], mosi_pin};
  always @(posedge ref_clk) if (result_valid_ff === 1'b1) valid_cnt++;

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic give_up(input logic hit);
    if (hit) begin
      failures++;
      tally_and_finish();
    end
  endtask : give_up

  function automatic logic [9:0] sample_for(input logic [3:0] ch);
    return {ch, ~ch, ch[3:2]};
  endfunction : sample_for

  // Holds start until the request is taken, then waits for the exchange to end.
  task automatic run_xchg(input logic [3:0] ch, input logic [9:0] val);
    int n;
    n         = 0;
    channel   = ch;
    sample_in = val;
    valid_cnt = 0;
    start     = 1'b1;
    while (busy !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    start = 1'b0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    // The valid strobe stands in the same cycle that busy falls; one more edge lets the monitor count it.
    @(posedge ref_clk);
    #1;
    give_up(n >= 3000);
  endtask : run_xchg

  task automatic s_first();
    check({sck_oe, mosi_oe, miso_oe, cs_n_ff}, 4'hD);
    run_xchg(4'h3, sample_for(4'h3));
    check(16'(valid_cnt), 16'h0000);
    check(16'(rise_cnt), 16'h0010);
    check(addr, 4'h3);
    check(cs_n_ff, 1'b1);
  endtask : s_first

  // Back-to-back exchanges over every channel; each start meets a conversion in progress.
  task automatic s_channels();
    logic [9:0] prev;
    logic [9:0] val;
    prev = sample_for(4'h3);
    for (int c = 0; c < 16; c++) begin
      val = sample_for(c[3:0]);
      run_xchg(c[3:0], val);
      check(result_ff, prev);
      check(result_hi_ff, prev[9:2]);
      check(result_lo_ff, {prev[1:0], 6'h00});
      check(16'(valid_cnt), 16'h0001);
      check(addr, c[3:0]);
      check(mosi_cap, {c[3:0], CHAN_PAD, c[3:0], CHAN_PAD});
      check(16'(rise_cnt), 16'h0010);
      check(conv_done, 1'b0);
      prev = val;
    end
    check(16'(bad_starts), 16'h0000);
    check({tail_err_ff, eoc_missed_ff}, 2'h0);
  endtask : s_channels

  task automatic s_faults();
    bad_tail = 1'b1;
    run_xchg(4'h5, sample_for(4'h5));
    check(tail_err_ff, 1'b1);
    bad_tail = 1'b0;
    bad_eoc  = 1'b1;
    run_xchg(4'h6, sample_for(4'h6));
    check(eoc_missed_ff, 1'b1);
    bad_eoc = 1'b0;
  endtask : s_faults

  // One byte each way as a slave, link clock at 125 ns.
  task automatic s_slave();
    logic [7:0] got;
    logic [7:0] tx;
    int         n;
    tx            = 8'h3C;
    got           = 8'h00;
    n             = 0;
    slave_mode    = 1'b1;
    slave_tx_byte = 8'hA5;
    repeat (3) @(posedge ref_clk);
    #1;
    check({sck_oe, mosi_oe, miso_oe}, 3'h0);
    ss_n_i = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    check(miso_oe, 1'b1);
    for (int i = 7; i >= 0; i--) begin
      #62.5;
      tb_mosi = tx[i];
      tb_sck  = 1'b1;
      #55;
      got[i]  = miso_pin;
      #7.5;
      tb_sck  = 1'b0;
    end
    while (slave_rx_valid_ff !== 1'b1 && n < 30) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    give_up(n >= 30);
    check(slave_rx_byte_ff, tx);
    check(got, 8'hA5);
    ss_n_i = 1'b1;
  endtask : s_slave

  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    s_first();
    s_channels();
    s_faults();
    s_slave();
    tally_and_finish();
  end
endmodule : adc_spi_master_reader_tb

`default_nettype wire
